// [inc/ars_pkg.sv]
// Constants and types for the auto-reclose sequencer.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package ars_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          TICK_US        = 1000;
  localparam int          TICK_CYCLES    = TICK_US * CLK_MHZ;
  localparam int          TMR_W          = 16;
  localparam int          CYC_W          = 3;
  localparam logic [2:0]  CYC_MAX        = 3'h4;
  localparam int          NUM_SHOTS      = 4;
  localparam int          REG_W          = 32;
  localparam int          ADDR_W         = 8;
  localparam int          DT_ENTRIES     = 8;
  // Register byte offsets.
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_ACT        = 8'h08;
  localparam logic [7:0]  OFF_MAXST      = 8'h0c;
  localparam logic [7:0]  OFF_RECLAIM    = 8'h10;
  localparam logic [7:0]  OFF_CBWAIT     = 8'h14;
  localparam logic [7:0]  OFF_DYNBLK     = 8'h18;
  localparam logic [7:0]  OFF_MANLOCK    = 8'h1c;
  localparam logic [7:0]  OFF_CLOSE      = 8'h20;
  localparam logic [7:0]  OFF_DT_BASE    = 8'h40;
  localparam logic [7:0]  OFF_DT_LAST    = 8'h5c;
  // Control field positions.
  localparam int          CTRL_OP_BIT    = 0;
  localparam int          CTRL_CB_BIT    = 1;
  localparam int          CTRL_CYC_LO    = 4;
  localparam logic [15:0] RST_TIME       = 16'h000a;
  typedef enum logic [2:0] {
    ARS_IDLE, ARS_ACTION, ARS_WAITSTART, ARS_DEAD, ARS_CBWAIT, ARS_CLOSE, ARS_RECLAIM,
    ARS_DYNBLK
  } ars_state_t;
endpackage : ars_pkg

// [inc/ars_dt_if.sv]
// Dead-time table access port between sequencer and its memory.
// Assumes one clock domain.
`timescale 1ns/1ps
interface ars_dt_if;
  import ars_pkg::*;
  logic              we;
  logic [2:0]        waddr;
  logic [TMR_W-1:0]  wdata;
  logic [2:0]        raddr;
  logic [TMR_W-1:0]  rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ars_dt_if

// [rtl/ars_dt_mem.sv]
// Dead-time table: four single-phase then four multi-phase entries.
// Assumes the writer and reader share CLK; read data is registered.
`timescale 1ns/1ps
module ars_dt_mem
  import ars_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST_N,
  ars_dt_if.mem     dt
);
  logic [TMR_W-1:0] mem [DT_ENTRIES];
  logic [TMR_W-1:0] rd;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd <= '0;
    end else begin
      rd <= mem[dt.raddr];
    end
  end

  genvar i;
  for (i = 0; i < DT_ENTRIES; i++) begin : g_ent
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        mem[i] <= RST_TIME;
      end else if (dt.we && dt.waddr == 3'(i)) begin
        mem[i] <= dt.wdata;
      end
    end
  end

  assign dt.rdata = rd;
endmodule : ars_dt_mem

// [rtl/ars_seq.sv]
// Auto-reclose sequencer with APB settings and per-shot dead times.
// Assumes inputs synchronous to CLK; timers count 1 ms ticks.
//
// Summary of operation
// - Up to four reclose attempts per fault sequence, each a cycle.
// - Each cycle has its own dead time for single and multi-phase faults.
// - Trip fall or breaker open starts dead time; expiry issues close.
// - Close starts reclaim; pickup before expiry advances to next cycle.
// - Reclaim expiry without pickup resets to first cycle.
// - Start begins action timer; no trip before expiry means dynamic block.
// - Trigger sets in-progress and starts maximum start-signal timer.
// - Close waits breaker ready up to supervision time, else block then reset.
// - Manual close inhibits reclosing for a programmed lockout.
// - Close pulse lasts its programmed time, cut short by any trip.
// - Cycle count selects none, one, two, three or four cycles.
// - On/off setting enables or disables the whole function.
// - User block input prevents automatic reclosing while asserted.
// - General device block also blocks reclosing.
// - Status outputs including in-progress are available externally.
`timescale 1ns/1ps
module ars_seq
  import ars_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [REG_W-1:0]  PWDATA,
  output logic [REG_W-1:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              PROTECTION_START_IN,
  input  wire logic              RECLOSE_TRIGGER_IN,
  input  wire logic              MULTI_PHASE_IN,
  input  wire logic              BREAKER_OPEN_IN,
  input  wire logic              BREAKER_READY_IN,
  input  wire logic              MANUAL_CLOSE_IN,
  input  wire logic              BLOCK_IN,
  input  wire logic              GENERAL_BLOCK_IN,
  output logic                   IN_PROGRESS_OUT,
  output logic                   CLOSE_OUT,
  output logic                   DYN_BLOCKED_OUT,
  output logic [2:0]             CYCLE_OUT
);
  ars_dt_if dt();
  ars_dt_mem u_mem (.CLK(CLK), .RST_N(RST_N), .dt(dt.mem));

  // Settings registers.
  logic             operation_switch, start_on_breaker_open;
  logic [2:0]       cycle_count_select;
  logic [TMR_W-1:0] action_time, start_signal_max_time, reclaim_time;
  logic [TMR_W-1:0] breaker_ready_wait_time, dynamic_block_time, manual_lock_time;
  logic [TMR_W-1:0] close_pulse_time;

  // Sequencer state.
  ars_state_t       state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr, lock_tmr, next_lock_tmr;
  logic [2:0]       cyc, next_cyc;
  logic             multi, next_multi;
  logic             trip_d, next_trip_d;
  logic             close_q, next_close_q;
  logic             dyn_q, next_dyn_q;
  logic             run_q, next_run_q;
  logic [$clog2(TICK_CYCLES)-1:0] div, next_div;
  logic             tick;

  // APB decode.
  logic             wr, rd, hit_dt;
  logic [REG_W-1:0] next_prdata;
  assign wr     = PSEL && PENABLE && PWRITE;
  assign rd     = PSEL && PENABLE && !PWRITE;
  assign hit_dt = PADDR >= OFF_DT_BASE && PADDR <= OFF_DT_LAST && PADDR[1:0] == 2'h0;
  assign PREADY = 1'b1;
  assign dt.we    = wr && hit_dt;
  assign dt.waddr = PADDR[4:2];
  assign dt.wdata = PWDATA[TMR_W-1:0];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      operation_switch        <= 1'b0;
      start_on_breaker_open   <= 1'b0;
      cycle_count_select      <= 3'h0;
      action_time             <= RST_TIME;
      start_signal_max_time   <= RST_TIME;
      reclaim_time            <= RST_TIME;
      breaker_ready_wait_time <= RST_TIME;
      dynamic_block_time      <= RST_TIME;
      manual_lock_time        <= RST_TIME;
      close_pulse_time        <= RST_TIME;
    end else if (wr) begin
      case (PADDR)
        OFF_CTRL: begin
          operation_switch      <= PWDATA[CTRL_OP_BIT];
          start_on_breaker_open <= PWDATA[CTRL_CB_BIT];
          cycle_count_select    <= (PWDATA[CTRL_CYC_LO+:3] > CYC_MAX) ? CYC_MAX
                                   : PWDATA[CTRL_CYC_LO+:3];
        end
        OFF_ACT:     action_time             <= PWDATA[TMR_W-1:0];
        OFF_MAXST:   start_signal_max_time   <= PWDATA[TMR_W-1:0];
        OFF_RECLAIM: reclaim_time            <= PWDATA[TMR_W-1:0];
        OFF_CBWAIT:  breaker_ready_wait_time <= PWDATA[TMR_W-1:0];
        OFF_DYNBLK:  dynamic_block_time      <= PWDATA[TMR_W-1:0];
        OFF_MANLOCK: manual_lock_time        <= PWDATA[TMR_W-1:0];
        OFF_CLOSE:   close_pulse_time        <= PWDATA[TMR_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_prdata = '0;
    PSLVERR     = 1'b0;
    case (PADDR)
      OFF_CTRL:    next_prdata = {25'h0, cycle_count_select, 2'h0, start_on_breaker_open,
                                  operation_switch};
      OFF_STATUS:  next_prdata = {16'h0, 5'h0, 3'(state), 2'h0, cyc, dyn_q, close_q, run_q};
      OFF_ACT:     next_prdata = {16'h0, action_time};
      OFF_MAXST:   next_prdata = {16'h0, start_signal_max_time};
      OFF_RECLAIM: next_prdata = {16'h0, reclaim_time};
      OFF_CBWAIT:  next_prdata = {16'h0, breaker_ready_wait_time};
      OFF_DYNBLK:  next_prdata = {16'h0, dynamic_block_time};
      OFF_MANLOCK: next_prdata = {16'h0, manual_lock_time};
      OFF_CLOSE:   next_prdata = {16'h0, close_pulse_time};
      default: begin
        PSLVERR     = PSEL && PENABLE && !hit_dt;
        next_prdata = '0;
      end
    endcase
  end

  // Dead-time reads go through the memory and are not readable over the bus.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_prdata;
    end
  end

  // Dead time of the next shot, chosen by fault type.
  assign dt.raddr = {next_multi, next_cyc[1:0]};

  // Tick divider.
  assign tick = (div == '0);
  always_comb begin
    next_div = tick ? ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1) : div - 1'b1;
  end

  logic inhibit, trip_fall, start_cond, tmr_done;
  assign inhibit    = !operation_switch || BLOCK_IN || GENERAL_BLOCK_IN ||
                      cycle_count_select == 3'h0 || lock_tmr != '0;
  assign trip_fall  = trip_d && !RECLOSE_TRIGGER_IN;
  assign start_cond = start_on_breaker_open ? BREAKER_OPEN_IN : trip_fall;
  assign tmr_done   = (tmr == '0);

  always_comb begin
    next_state    = state;
    next_tmr      = (tick && tmr != '0) ? tmr - 1'b1 : tmr;
    next_cyc      = cyc;
    next_multi    = multi;
    next_trip_d   = RECLOSE_TRIGGER_IN;
    next_close_q  = 1'b0;
    next_dyn_q    = 1'b0;
    next_run_q    = run_q;
    next_lock_tmr = (tick && lock_tmr != '0) ? lock_tmr - 1'b1 : lock_tmr;
    if (MANUAL_CLOSE_IN) begin
      next_lock_tmr = manual_lock_time;
    end
    case (state)
      ARS_IDLE: begin
        next_cyc   = 3'h0;
        next_run_q = 1'b0;
        next_multi = 1'b0;
        if (!inhibit && RECLOSE_TRIGGER_IN) begin
          next_state = ARS_WAITSTART;
          next_tmr   = start_signal_max_time;
          next_run_q = 1'b1;
          next_multi = MULTI_PHASE_IN;
        end else if (!inhibit && PROTECTION_START_IN) begin
          next_state = ARS_ACTION;
          next_tmr   = action_time;
        end
      end
      ARS_ACTION: begin
        if (inhibit) begin
          next_state = ARS_IDLE;
        end else if (RECLOSE_TRIGGER_IN) begin
          next_state = ARS_WAITSTART;
          next_tmr   = start_signal_max_time;
          next_run_q = 1'b1;
          next_multi = multi || MULTI_PHASE_IN;
        end else if (tmr_done) begin
          next_state = ARS_DYNBLK;
          next_tmr   = dynamic_block_time;
        end
      end
      ARS_WAITSTART: begin
        if (RECLOSE_TRIGGER_IN && MULTI_PHASE_IN) begin
          next_multi = 1'b1;
        end
        if (inhibit) begin
          next_state = ARS_IDLE;
        end else if (start_cond) begin
          next_state = ARS_DEAD;
          next_tmr   = dt.rdata;
        end else if (tmr_done) begin
          next_state = ARS_DYNBLK;
          next_tmr   = dynamic_block_time;
        end
      end
      ARS_DEAD: begin
        if (inhibit) begin
          next_state = ARS_IDLE;
        end else if (tmr_done) begin
          next_state = ARS_CBWAIT;
          next_tmr   = breaker_ready_wait_time;
        end
      end
      ARS_CBWAIT: begin
        if (inhibit) begin
          next_state = ARS_IDLE;
        end else if (BREAKER_READY_IN) begin
          next_state   = ARS_CLOSE;
          next_tmr     = close_pulse_time;
          next_close_q = 1'b1;
          next_cyc     = cyc + 3'h1;
        end else if (tmr_done) begin
          next_state = ARS_DYNBLK;
          next_tmr   = dynamic_block_time;
        end
      end
      ARS_CLOSE: begin
        next_close_q = 1'b1;
        if (RECLOSE_TRIGGER_IN || tmr_done) begin
          next_close_q = 1'b0;
          next_state   = ARS_RECLAIM;
          next_tmr     = reclaim_time;
        end
      end
      ARS_RECLAIM: begin
        if (PROTECTION_START_IN || RECLOSE_TRIGGER_IN) begin
          if (inhibit || cyc >= cycle_count_select) begin
            next_state = ARS_DYNBLK;
            next_tmr   = dynamic_block_time;
          end else if (RECLOSE_TRIGGER_IN) begin
            next_state = ARS_WAITSTART;
            next_tmr   = start_signal_max_time;
            next_multi = multi || MULTI_PHASE_IN;
          end else begin
            next_state = ARS_ACTION;
            next_tmr   = action_time;
          end
        end else if (tmr_done) begin
          next_state = ARS_IDLE;
        end
      end
      ARS_DYNBLK: begin
        if (tmr_done) begin
          next_state = ARS_IDLE;
          next_dyn_q = 1'b0;
        end
      end
      default: next_state = ARS_IDLE;
    endcase
    if (next_state == ARS_DYNBLK) begin
      next_dyn_q = 1'b1;
      next_run_q = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state    <= ARS_IDLE;
      tmr      <= '0;
      lock_tmr <= '0;
      cyc      <= 3'h0;
      multi    <= 1'b0;
      trip_d   <= 1'b0;
      close_q  <= 1'b0;
      dyn_q    <= 1'b0;
      run_q    <= 1'b0;
      div      <= '0;
    end else begin
      state    <= next_state;
      tmr      <= next_tmr;
      lock_tmr <= next_lock_tmr;
      cyc      <= next_cyc;
      multi    <= next_multi;
      trip_d   <= next_trip_d;
      close_q  <= next_close_q;
      dyn_q    <= next_dyn_q;
      run_q    <= next_run_q;
      div      <= next_div;
    end
  end

  assign IN_PROGRESS_OUT = run_q;
  assign CLOSE_OUT       = close_q;
  assign DYN_BLOCKED_OUT = dyn_q;
  assign CYCLE_OUT       = cyc;

  sequence s_close_start;
    state == ARS_CBWAIT && !inhibit && BREAKER_READY_IN;
  endsequence

  AST_CLOSE_ON_READY: assert property (@(posedge CLK) disable iff (!RST_N)
    s_close_start |=> CLOSE_OUT && state == ARS_CLOSE)
    else $error("close not issued on breaker ready");
  AST_CLOSE_CUT: assert property (@(posedge CLK) disable iff (!RST_N)
    state == ARS_CLOSE && RECLOSE_TRIGGER_IN |=> !CLOSE_OUT && state == ARS_RECLAIM)
    else $error("close pulse not ended by trip");
  AST_MAX_SHOTS: assert property (@(posedge CLK) disable iff (!RST_N)
    cyc <= CYC_MAX)
    else $error("cycle count above four");
  AST_CYC_LIMIT: assert property (@(posedge CLK) disable iff (!RST_N)
    CLOSE_OUT && $rose(CLOSE_OUT) |-> cyc <= cycle_count_select)
    else $error("cycle beyond selected count");
  AST_RUN_ON_TRIGGER: assert property (@(posedge CLK) disable iff (!RST_N)
    state == ARS_IDLE && !inhibit && RECLOSE_TRIGGER_IN |=> IN_PROGRESS_OUT)
    else $error("in-progress not set on trigger");
  AST_ACTION_EXPIRY: assert property (@(posedge CLK) disable iff (!RST_N)
    state == ARS_ACTION && !inhibit && !RECLOSE_TRIGGER_IN && tmr_done |=> DYN_BLOCKED_OUT)
    else $error("action expiry did not block");
  AST_RECLAIM_RESET: assert property (@(posedge CLK) disable iff (!RST_N)
    state == ARS_RECLAIM && tmr_done && !PROTECTION_START_IN && !RECLOSE_TRIGGER_IN
    |=> state == ARS_IDLE ##1 CYCLE_OUT == 3'h0)
    else $error("reclaim expiry did not reset");
  AST_CB_TIMEOUT: assert property (@(posedge CLK) disable iff (!RST_N)
    state == ARS_CBWAIT && !inhibit && !BREAKER_READY_IN && tmr_done
    |=> state == ARS_DYNBLK && !IN_PROGRESS_OUT && DYN_BLOCKED_OUT)
    else $error("breaker wait timeout not handled");
  AST_BLOCK_NO_CLOSE: assert property (@(posedge CLK) disable iff (!RST_N)
    BLOCK_IN || GENERAL_BLOCK_IN |=> !$rose(CLOSE_OUT))
    else $error("close raised while blocked");
endmodule : ars_seq

// [verif/ars_far.sv]
// Far-side model: protection pickup and trip, plus a breaker that opens on trip.
// Assumes CLK at 100 MHz; after time zero every output but brk_ready changes by non-blocking assignment.
`timescale 1ns/1ps
module ars_far (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ready_en,
  input  wire logic close_in,
  output logic      start,
  output logic      trip,
  output logic      multi,
  output logic      brk_open,
  output logic      brk_ready
);
  initial begin
    start    = 1'b0;
    trip     = 1'b0;
    multi    = 1'b0;
    brk_open = 1'b0;
  end
  // Breaker readiness is decided by the bench so slow breakers can be modelled.
  assign brk_ready = ready_en;
  // A close command recloses the breaker.
  always @(posedge clk) begin
    if (rst_n !== 1'b1 || close_in === 1'b1) brk_open <= 1'b0;
  end
  // One fault: pickup, a one-cycle trip, then trip reset with the breaker opening.
  // Bench timers are zero, so trip must follow pickup at once and reset at once.
  task automatic pickup(input bit do_trip, input bit mph);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    trip  <= do_trip;
    multi <= mph;
    @(posedge clk);
    trip     <= 1'b0;
    start    <= 1'b0;
    brk_open <= do_trip;
  endtask : pickup
endmodule : ars_far

// [verif/tb.sv]
// Self-checking bench for the auto-reclose sequencer.
// Assumes ars_far drives the protection and breaker inputs.
`timescale 1ns/1ps
module tb;
  import ars_pkg::*;
  logic              clk;
  logic              rst_n;
  logic              psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [REG_W-1:0]  pwdata, prdata, rd, w;
  logic              start, trip, multi, brk_open, brk_ready;
  logic              manual, blk, gblk, ready_en, err, close_q;
  logic              in_prog, close_o, dyn_o;
  logic [2:0]        cyc_o;
  logic [31:0]       seed;
  logic [31:0]       expq[$];
  int                miscompares = 0;
  int                checks = 0;
  int                cycles = 0;
  int                close_cnt = 0;
  int                dyn_seen = 0;

  ars_seq i_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PROTECTION_START_IN(start), .RECLOSE_TRIGGER_IN(trip), .MULTI_PHASE_IN(multi),
    .BREAKER_OPEN_IN(brk_open), .BREAKER_READY_IN(brk_ready), .MANUAL_CLOSE_IN(manual),
    .BLOCK_IN(blk), .GENERAL_BLOCK_IN(gblk), .IN_PROGRESS_OUT(in_prog),
    .CLOSE_OUT(close_o), .DYN_BLOCKED_OUT(dyn_o), .CYCLE_OUT(cyc_o));
  ars_far i_far (.clk(clk), .rst_n(rst_n), .ready_en(ready_en), .close_in(close_o),
    .start(start), .trip(trip), .multi(multi), .brk_open(brk_open), .brk_ready(brk_ready));

  always #5 clk = ~clk;
  // Counts close pulses and remembers any dynamic block.
  always @(posedge clk) begin
    if (close_o === 1'b1 && close_q !== 1'b1) close_cnt++;
    close_q = close_o;
    if (dyn_o === 1'b1) dyn_seen = 1;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Resets the block, zeroes every timer and dead time, then sets control.
  task automatic setup(input logic [31:0] ctrl);
    @(posedge clk);
    rst_n    <= 1'b0;
    manual   <= 1'b0;
    blk      <= 1'b0;
    gblk     <= 1'b0;
    ready_en <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    close_cnt = 0;
    dyn_seen  = 0;
    for (int a = 8; a < 8'h60; a += 4) begin
      if (a < 8'h24 || a > 8'h3c) apb(1'b1, 8'(a), 32'h0);
    end
    apb(1'b1, OFF_CTRL, ctrl);
  endtask : setup

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    manual = 1'b0;
    blk = 1'b0;
    gblk = 1'b0;
    ready_en = 1'b1;
    seed = 32'd58;
    repeat (16) @(posedge clk);
    chk({close_o, in_prog, dyn_o, cyc_o}, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, OFF_ACT, 32'h0);
    chk(rd, {16'h0, RST_TIME});
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 7; i++) begin
      w = rnd() & 32'hffff;
      expq.push_back(w);
      apb(1'b1, OFF_ACT + 8'(4 * i), w);
    end
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, OFF_ACT + 8'(4 * i), 32'h0);
      chk(rd, expq.pop_front());
    end
    apb(1'b1, OFF_DT_BASE + 8'h04, rnd() & 32'hffff);
    apb(1'b0, OFF_DT_BASE + 8'h04, 32'h0);
    chk({err, rd[30:0]}, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, OFF_CTRL, 32'h71);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h41);
    $display("test registers done");
    // Permanent fault against every cycle-count selection.
    for (int s = 0; s <= 4; s++) begin
      setup(32'h1 | 32'(s << 4));
      apb(1'b1, OFF_RECLAIM, 32'h1);
      for (int k = 0; k <= s; k++) begin
        i_far.pickup(1'b1, k[0]);
        repeat (60) @(posedge clk);
        chk(close_cnt, (k < s) ? k + 1 : s);
        if (k < s) chk(cyc_o, k + 1);
      end
      if (s > 0) chk(dyn_seen, 1);
      $display("test cycles %0d done", s);
    end
    // Off switch, block, general block and manual-close lockout.
    for (int m = 0; m < 4; m++) begin
      setup(m == 0 ? 32'h10 : 32'h11);
      apb(1'b1, OFF_MANLOCK, 32'h1);
      blk    <= (m == 1);
      gblk   <= (m == 2);
      manual <= (m == 3);
      i_far.pickup(1'b1, 1'b0);
      manual <= 1'b0;
      repeat (60) @(posedge clk);
      chk(close_cnt, 0);
      $display("test inhibit %0d done", m);
    end
    setup(32'h11);
    i_far.pickup(1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk(dyn_seen, 1);
    chk(close_cnt, 0);
    $display("test action timer done");
    setup(32'h11);
    ready_en <= 1'b0;
    i_far.pickup(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    chk(dyn_seen, 1);
    chk(close_cnt, 0);
    $display("test breaker not ready done");
    setup(32'h13);
    i_far.pickup(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    chk(close_cnt, 1);
    $display("test breaker open start done");
    setup(32'h11);
    apb(1'b1, OFF_DT_BASE + 8'h10, 32'h1);
    i_far.pickup(1'b1, 1'b0);
    repeat (20) @(posedge clk);
    chk(close_cnt, 1);
    i_far.pickup(1'b1, 1'b1);
    repeat (20) @(posedge clk);
    chk(close_cnt, 1);
    chk(in_prog, 1);
    $display("test dead time select done");
    setup(32'h11);
    apb(1'b1, OFF_CLOSE, 32'h1);
    apb(1'b1, OFF_RECLAIM, 32'h1);
    i_far.pickup(1'b1, 1'b0);
    for (int i = 0; i < 40 && close_o !== 1'b1; i++) @(posedge clk);
    chk(close_o, 1);
    chk(in_prog, 1);
    fork
      i_far.pickup(1'b1, 1'b0);
      begin
        repeat (6) @(posedge clk);
        chk(close_o, 0);
      end
    join
    $display("test close cut by trip done");
    conclude();
  end
endmodule : tb
